//--- src/scf_core.sv
// Serial peripheral unit: baud generation, auto select, single-pin data, mode fault, power modes
`timescale 1ns/1ps
module scf_core (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Control register writes and status read strobe
	input wire logic ctl1_wr,
	input wire scf_pkg::scf_ctl1_t ctl1_wdata,
	input wire logic ctl2_wr,
	input wire scf_pkg::scf_ctl2_t ctl2_wdata,
	input wire scf_pkg::scf_baud_t baud,
	input wire logic status_rd,
	input wire logic done_clr,
	// Power modes
	input wire logic wait_mode,
	input wire logic stop_mode,
	// Data register write
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	output logic tx_ready,
	// Received data
	output logic rx_valid,
	output logic [7:0] rx_data,
	input wire logic rx_ready,
	// Register readback
	output scf_pkg::scf_status_t status,
	output scf_pkg::scf_ctl1_t ctl1,
	output scf_pkg::scf_ctl2_t ctl2,
	// Serial clock pin
	input wire logic sck_in,
	output logic sck_out,
	output logic sck_oe,
	// Data pins
	input wire logic mosi_in,
	output logic mosi_out,
	output logic mosi_oe,
	input wire logic miso_in,
	output logic miso_out,
	output logic miso_oe,
	// Slave select pin
	input wire logic sel_n_in,
	output logic sel_n_out,
	output logic sel_n_oe
);
	import scf_pkg::*;

	typedef enum logic [1:0] {ST_IDLE, ST_MXFER, ST_SXFER} scf_state_t;

	scf_state_t state;
	logic [3:0] s1, s2, s3, filt, fprev;
	logic [7:0] shreg, tx_hold, tx_last, pend_data;
	logic [4:0] edge_cnt;
	logic in_bit, sck_lvl, tx_full, dr_mode, sel_fresh;
	logic pend_done, clr_arm, fault_flag, done_flag;
	logic baud_tick;

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers: a change counts once stages two and three agree
	wire [3:0] agree = ~(s2 ^ s3);
	wire [3:0] next_filt = (agree & s3) | (~agree & filt);

	always_ff @(posedge clk) begin
		if (rst) begin
			s1 <= SCF_SYNC_RST;
			s2 <= SCF_SYNC_RST;
			s3 <= SCF_SYNC_RST;
			filt <= SCF_SYNC_RST;
			fprev <= SCF_SYNC_RST;
		end else begin
			s1 <= {miso_in, mosi_in, sel_n_in, sck_in};
			s2 <= s1;
			s3 <= s2;
			filt <= next_filt;
			fprev <= filt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Mode decoding
	wire en = ctl1.module_enable;
	wire is_master = en && ctl1.master_select;
	wire is_slave = en && !ctl1.master_select;
	wire bidi = ctl2.single_pin_data_mode;
	wire sel_low = !filt[SCF_PIN_SEL];
	// wait with stop-in-wait, or stop, is low power
	wire low_power = stop_mode || (wait_mode && ctl2.stop_in_wait);
	// auto select needs master, output enable and fault detect
	wire auto_sel = is_master && ctl1.select_output_enable && ctl1.fault_detect_enable;
	// low select input as detecting master is a fault
	// detect clear or slave never faults
	wire fault_det = is_master && ctl1.fault_detect_enable && !ctl1.select_output_enable && sel_low;
	// Pins may drive only with no fault pending or standing
	wire drive_ok = en && !fault_flag && !fault_det;

	// single-pin mode picks MOSI as master, MISO as slave
	// the shared pin always feeds the shift input
	wire m_sin = bidi ? filt[SCF_PIN_MOSI] : filt[SCF_PIN_MISO];
	wire s_sin = bidi ? filt[SCF_PIN_MISO] : filt[SCF_PIN_MOSI];
	wire s_rise = filt[SCF_PIN_SCK] && !fprev[SCF_PIN_SCK];
	wire s_fall = !filt[SCF_PIN_SCK] && fprev[SCF_PIN_SCK];

	////////////////////////////////////////////////////////////////////////////
	// Transfer control
	// divider runs only for a master transfer
	// and halts while in low power
	wire buf_ready;
	wire baud_run = (state == ST_MXFER) && !low_power && !fault_det;
	wire m_tick = baud_tick && baud_run;
	wire m_start = (state == ST_IDLE) && is_master && !fault_det && tx_full && buf_ready && !low_power;
	wire s_start = (state == ST_IDLE) && is_slave && sel_low;
	wire s_edge = (state == ST_SXFER) && (s_rise || s_fall);
	wire step = m_tick || s_edge;
	wire odd_edge = !edge_cnt[0];
	wire done_evt = step && (edge_cnt == SCF_LAST_EDGE);
	wire [7:0] done_data = {shreg[6:0], in_bit};
	wire slave_lp = is_slave && low_power;

	// deferred copy releases on exit; new done waits one cycle
	wire pend_release = pend_done && !low_power;
	wire push_now = pend_release || (done_evt && !slave_lp);
	wire [7:0] push_data = pend_release ? pend_data : done_data;
	wire next_pend = (done_evt && (slave_lp || pend_release)) || (pend_done && !pend_release);
	wire tx_take = tx_valid && tx_ready;

	// slave reload: data register if fresh, same byte in low power
	// otherwise last received byte stays in the shifter
	wire s_load_dr = tx_full && sel_fresh && !low_power;
	wire s_load_same = low_power && dr_mode;

	scf_baud u_baud (
		.clk(clk),
		.rst(rst),
		.run(baud_run),
		.baud(baud),
		.tick(baud_tick)
	);

	// State sequencing; fault and disable abort to idle
	always_ff @(posedge clk) begin
		if (rst) begin
			state <= ST_IDLE;
		end else if (!en || fault_det) begin
			state <= ST_IDLE;
		end else begin
			unique case (state)
				ST_IDLE: begin
					if (m_start) state <= ST_MXFER;
					else if (s_start) state <= ST_SXFER;
				end
				ST_MXFER: begin
					if (done_evt) state <= ST_IDLE;
				end
				ST_SXFER: begin
					if (done_evt || !sel_low) state <= ST_IDLE;
				end
			endcase
		end
	end

	// Shifter, edge count and master clock level
	always_ff @(posedge clk) begin
		if (rst) begin
			shreg <= SCF_DATA_RST;
			edge_cnt <= '0;
			in_bit <= 1'b0;
			sck_lvl <= 1'b0;
			dr_mode <= 1'b0;
		end else if (m_start) begin
			shreg <= tx_hold;
			edge_cnt <= '0;
			sck_lvl <= 1'b0;
		end else if (s_start) begin
			// byte type chosen at entry is kept during low power
			if (s_load_dr) shreg <= tx_hold;
			else if (s_load_same) shreg <= tx_last;
			if (!low_power) dr_mode <= s_load_dr;
			edge_cnt <= '0;
		end else if (step) begin
			// master clock toggles each half period
			if (m_tick) sck_lvl <= !sck_lvl;
			if (odd_edge) in_bit <= (state == ST_MXFER) ? m_sin : s_sin;
			else shreg <= done_data;
			edge_cnt <= edge_cnt + 5'h01;
		end else if (state == ST_IDLE) begin
			sck_lvl <= 1'b0;
		end
	end

	// Data register holding stage
	always_ff @(posedge clk) begin
		if (rst) begin
			tx_hold <= SCF_DATA_RST;
			tx_last <= SCF_DATA_RST;
			tx_full <= 1'b0;
			tx_ready <= 1'b1;
			sel_fresh <= 1'b1;
		end else begin
			if (tx_take) tx_hold <= tx_data;
			if (m_start || (s_start && s_load_dr)) tx_last <= tx_hold;
			tx_full <= tx_take || (tx_full && !(m_start || (s_start && s_load_dr)));
			tx_ready <= !(tx_take || (tx_full && !(m_start || (s_start && s_load_dr))));
			if (!sel_low) sel_fresh <= 1'b1;
			else if (s_start) sel_fresh <= 1'b0;
		end
	end

	// Received words; master waits on a full buffer, slave overrun is dropped
	scf_buf2 #(
		.W(SCF_DATA_W),
		.DEPTH(SCF_BUF_DEPTH)
	) u_rxbuf (
		.clk(clk),
		.rst(rst),
		.in_valid(push_now),
		.in_data(push_data),
		.in_ready(buf_ready),
		.out_valid(rx_valid),
		.out_data(rx_data),
		.out_ready(rx_ready)
	);

	////////////////////////////////////////////////////////////////////////////
	// Flags; a set in the clearing cycle wins
	always_ff @(posedge clk) begin
		if (rst) begin
			fault_flag <= 1'b0;
			clr_arm <= 1'b0;
			done_flag <= 1'b0;
			pend_done <= 1'b0;
			pend_data <= SCF_DATA_RST;
		end else begin
			// read with flag set arms, control one write clears
			fault_flag <= fault_det || (fault_flag && !(ctl1_wr && clr_arm));
			if (ctl1_wr) clr_arm <= 1'b0;
			else if (status_rd && fault_flag) clr_arm <= 1'b1;
			done_flag <= push_now || (done_flag && !done_clr);
			// hold the slave result until low power ends
			pend_done <= next_pend;
			if (done_evt && (slave_lp || pend_release)) pend_data <= done_data;
		end
	end

	// Control registers stay writable while disabled
	always_ff @(posedge clk) begin
		if (rst) begin
			ctl1 <= SCF_CTL1_RST;
			ctl2 <= SCF_CTL2_RST;
		end else begin
			if (ctl1_wr) ctl1 <= ctl1_wdata;
			if (ctl2_wr) ctl2 <= ctl2_wdata;
			if (fault_det) ctl1.master_select <= 1'b0;
			// fault in single-pin master drops the pin enable
			if (fault_det && bidi) ctl2.single_pin_output_enable <= 1'b0;
		end
	end

	assign status = '{fault_flag: fault_flag, transfer_done_flag: done_flag,
		master_select: ctl1.master_select, busy: (state != ST_IDLE)};

	////////////////////////////////////////////////////////////////////////////
	// Pin drivers, registered
	// clock drives as master only; select never drives as slave
	wire m_drive = drive_ok && ctl1.master_select;
	wire s_drive = drive_ok && !ctl1.master_select && sel_low;
	wire pin_dir = bidi ? ctl2.single_pin_output_enable : 1'b1;

	always_ff @(posedge clk) begin
		if (rst) begin
			sck_out <= 1'b0;
			sck_oe <= 1'b0;
			mosi_out <= 1'b0;
			mosi_oe <= 1'b0;
			miso_out <= 1'b0;
			miso_oe <= 1'b0;
			sel_n_out <= 1'b1;
			sel_n_oe <= 1'b0;
		end else begin
			sck_out <= sck_lvl;
			sck_oe <= m_drive;
			mosi_out <= shreg[7];
			mosi_oe <= m_drive && pin_dir;
			miso_out <= shreg[7];
			miso_oe <= s_drive && pin_dir;
			// select low during a transfer, high idle
			sel_n_out <= (state != ST_MXFER);
			sel_n_oe <= auto_sel && drive_ok;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	sequence fault_hit;
		fault_det;
	endsequence

	sequence pins_off;
		!sck_oe && !mosi_oe && !miso_oe;
	endsequence

	div_gate_a: assert property (@(posedge clk) disable iff (rst)
		m_tick |-> (state == ST_MXFER) && ctl1.master_select)
		else $error("divider stepped outside a master transfer");

	sel_auto_a: assert property (@(posedge clk) disable iff (rst)
		(auto_sel && drive_ok && state == ST_MXFER) |=> !sel_n_out && sel_n_oe)
		else $error("auto select not low during transfer");

	sel_gate_a: assert property (@(posedge clk) disable iff (rst)
		sel_n_oe |-> $past(ctl1.select_output_enable && ctl1.fault_detect_enable))
		else $error("select driven without both enables");

	fault_set_a: assert property (@(posedge clk) disable iff (rst)
		fault_hit |=> fault_flag && !ctl1.master_select)
		else $error("fault not flagged or master kept");

	fault_ignore_a: assert property (@(posedge clk) disable iff (rst)
		(!fault_flag && (!ctl1.fault_detect_enable || !ctl1.master_select)) |=> !fault_flag)
		else $error("fault flagged with detection off");

	fault_abort_a: assert property (@(posedge clk) disable iff (rst)
		fault_hit |=> (state == ST_IDLE) ##0 pins_off)
		else $error("fault did not abort and release pins");

	pin_clear_a: assert property (@(posedge clk) disable iff (rst)
		(fault_det && bidi) |=> !ctl2.single_pin_output_enable)
		else $error("single-pin enable kept after fault");

	fault_clear_a: assert property (@(posedge clk) disable iff (rst)
		(status_rd && fault_flag && !ctl1_wr) ##1 (ctl1_wr && !fault_det) |=> !fault_flag)
		else $error("fault flag not cleared by read then write");

	lp_halt_a: assert property (@(posedge clk) disable iff (rst)
		(state == ST_MXFER && low_power && en && !fault_det) |=> $stable(edge_cnt) && state == ST_MXFER)
		else $error("master moved during low power");

	defer_done_a: assert property (@(posedge clk) disable iff (rst)
		(done_evt && slave_lp) |=> pend_done)
		else $error("slave completion not deferred");

	disable_idle_a: assert property (@(posedge clk) disable iff (rst)
		!en |=> (state == ST_IDLE) ##0 pins_off)
		else $error("disabled core still active");

endmodule

//--- src/scf_pkg.sv
// Shared constants, carrier types and divisor arithmetic for the serial unit
package scf_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Widths and counts
	localparam int SCF_DATA_W = 8;
	localparam int SCF_HALF_W = 11;
	localparam int SCF_BUF_DEPTH = 2;
	localparam logic [4:0] SCF_LAST_EDGE = 5'h0f;

	// Reset values
	localparam logic [7:0] SCF_DATA_RST = 8'h00;
	localparam logic [3:0] SCF_SYNC_RST = 4'hf;

	// Indices into the synchronised pin vector
	localparam int SCF_PIN_SCK = 0;
	localparam int SCF_PIN_SEL = 1;
	localparam int SCF_PIN_MOSI = 2;
	localparam int SCF_PIN_MISO = 3;

	////////////////////////////////////////////////////////////////////////////
	// Control register one fields
	typedef struct packed {
		logic module_enable;
		logic master_select;
		logic select_output_enable;
		logic fault_detect_enable;
	} scf_ctl1_t;

	// Control register two fields
	typedef struct packed {
		logic single_pin_data_mode;
		logic single_pin_output_enable;
		logic stop_in_wait;
	} scf_ctl2_t;

	// Baud fields
	typedef struct packed {
		logic [2:0] baud_preselect_field;
		logic [2:0] baud_select_field;
	} scf_baud_t;

	// Status view
	typedef struct packed {
		logic fault_flag;
		logic transfer_done_flag;
		logic master_select;
		logic busy;
	} scf_status_t;

	localparam scf_ctl1_t SCF_CTL1_RST = '0;
	localparam scf_ctl2_t SCF_CTL2_RST = '0;

	////////////////////////////////////////////////////////////////////////////
	// Half period in module clocks: (pre + 1) * 2^sel, half of the divisor
	function automatic logic [SCF_HALF_W-1:0] scf_half(input scf_baud_t b);
		logic [SCF_HALF_W-1:0] p;
		p = {8'h00, b.baud_preselect_field} + 11'h001;
		scf_half = p << b.baud_select_field;
	endfunction

endpackage

//--- src/scf_baud.sv
// Baud divider: one-cycle tick at each serial clock half period
`timescale 1ns/1ps
module scf_baud (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Control
	input wire logic run,
	input wire scf_pkg::scf_baud_t baud,
	// Half-period enable
	output logic tick
);
	import scf_pkg::*;

	logic [SCF_HALF_W-1:0] cnt;
	wire [SCF_HALF_W-1:0] half;
	wire last;

	assign half = scf_half(baud);
	assign last = (cnt == half - 11'h001);

	// all-zero fields tick every cycle, divide by two
	always_ff @(posedge clk) begin
		if (rst || !run) begin
			cnt <= '0;
			tick <= 1'b0;
		end else if (last) begin
			cnt <= '0;
			tick <= 1'b1;
		end else begin
			cnt <= cnt + 11'h001;
			tick <= 1'b0;
		end
	end

	// Count must wrap exactly at half a divisor
	div_period_a: assert property (@(posedge clk) disable iff (rst)
		(tick && $past(run) && $stable(baud)) |-> ($past(cnt) == half - 11'h001))
		else $error("divider tick off its half period");

	// No tick while the divider is stopped
	div_stop_a: assert property (@(posedge clk) disable iff (rst)
		!run |=> !tick)
		else $error("divider ticked while stopped");

endmodule

//--- src/scf_buf2.sv
// Small receive buffer with valid and ready on both sides
`timescale 1ns/1ps
module scf_buf2 #(
	parameter int W = 8,
	parameter int DEPTH = 2
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Fill side
	input wire logic in_valid,
	input wire logic [W-1:0] in_data,
	output logic in_ready,
	// Drain side
	output logic out_valid,
	output logic [W-1:0] out_data,
	input wire logic out_ready
);
	import scf_pkg::*;

	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
	localparam logic [AW-1:0] LASTP = AW'(DEPTH - 1);

	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wr;
	logic [AW-1:0] rd;
	logic [AW:0] count;
	wire push;
	wire pop;
	wire [AW:0] next_count;

	// Handshakes on both sides
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
	assign out_data = mem[rd];

	// storage clears so reads show zero after reset
	always_ff @(posedge clk) begin
		if (rst) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem[i] <= SCF_DATA_RST;
			end
		end else if (push) begin
			mem[wr] <= in_data;
		end
	end

	// Pointers and registered flags, so full and empty stay honest
	always_ff @(posedge clk) begin
		if (rst) begin
			wr <= '0;
			rd <= '0;
			count <= '0;
			in_ready <= 1'b1;
			out_valid <= 1'b0;
		end else begin
			if (push) wr <= (wr == LASTP) ? '0 : wr + 1'b1;
			if (pop) rd <= (rd == LASTP) ? '0 : rd + 1'b1;
			count <= next_count;
			in_ready <= (next_count != FULL);
			out_valid <= (next_count != '0);
		end
	end

endmodule

//--- dv/scf_peer.sv
// Behavioural remote slave on the serial bus: clock idle low, sample rising, msb first
`timescale 1ns/1ps
module scf_peer (
	// Bus pins
	input wire logic sck,
	input wire logic sel_n,
	input wire logic mosi,
	output logic miso,
	// Byte to return and byte last taken
	input wire logic [7:0] reply,
	output logic [7:0] got
);
	logic [7:0] sh;
	logic [7:0] rx;

	////////////////////////////////////////////////////////////////////////////
	// Idle state
	initial begin
		miso = 1'b1;
		sh = 8'h00;
		rx = 8'h00;
		got = 8'h00;
	end

	// Load on select; first bit is out before any clock edge
	always @(negedge sel_n) begin
		sh = reply;
		miso = sh[7];
	end

	// Sample on the rising clock
	always @(posedge sck) begin
		if (!sel_n) begin
			rx = {rx[6:0], mosi};
		end
	end

	// Shift on the falling clock
	always @(negedge sck) begin
		if (!sel_n) begin
			sh = {sh[6:0], 1'b0};
			miso = sh[7];
		end
	end

	// Released line shows the inverse, so a stale bit cannot pass for data
	always @(posedge sel_n) begin
		got = rx;
		miso = ~miso;
	end
endmodule

//--- dv/spi_clocking_modes_and_fault_tb.sv
// Self-checking bench for the serial unit: divider, auto select, stall, wait, mode fault
`timescale 1ns/1ps
module spi_clocking_modes_and_fault_tb;
	import scf_pkg::*;

	logic clk;
	logic rst;
	logic ctl1_wr, ctl2_wr, status_rd, done_clr, wait_mode, tx_valid, rx_ready, ext_sel_n;
	scf_ctl1_t ctl1_wdata, ctl1;
	scf_ctl2_t ctl2_wdata, ctl2;
	scf_baud_t baud;
	scf_status_t status;
	logic [7:0] tx_data, rx_data, peer_reply, peer_got;
	logic tx_ready, rx_valid, sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe;
	logic sel_n_out, sel_n_oe, peer_miso, last_sck, sel_bad;
	int bad_count, comparisons, cyc, toggles, gap, gmin, gmax, half, snap;
	int pre_t[7] = '{0, 0, 0, 1, 2, 4, 1};
	int sel_t[7] = '{0, 1, 2, 0, 0, 0, 2};

	////////////////////////////////////////////////////////////////////////////
	// Pin levels from every party's enable; released clock pulled low, MOSI high, select from ext_sel_n, MISO from the peer
	wire logic sck_w = sck_oe ? sck_out : 1'b0;
	wire logic sel_w = sel_n_oe ? sel_n_out : ext_sel_n;
	wire logic mosi_w = mosi_oe ? mosi_out : 1'b1;
	wire logic miso_w = miso_oe ? miso_out : peer_miso;

	scf_core dut (
		.clk, .rst, .ctl1_wr, .ctl1_wdata, .ctl2_wr, .ctl2_wdata, .baud, .status_rd, .done_clr,
		.wait_mode, .stop_mode(1'b0), .tx_valid, .tx_data, .tx_ready, .rx_valid, .rx_data, .rx_ready,
		.status, .ctl1, .ctl2, .sck_in(sck_w), .sck_out, .sck_oe, .mosi_in(mosi_w), .mosi_out, .mosi_oe,
		.miso_in(miso_w), .miso_out, .miso_oe, .sel_n_in(sel_w), .sel_n_out, .sel_n_oe
	);

	scf_peer peer (
		.sck(sck_w), .sel_n(sel_w), .mosi(mosi_w), .miso(peer_miso), .reply(peer_reply), .got(peer_got)
	);

	// Clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Half-period and select watch; also the hang limit
	always @(posedge clk) begin
		if (sck_out !== last_sck) begin
			if (toggles > 0 && gap < gmin) gmin = gap;
			if (toggles > 0 && gap > gmax) gmax = gap;
			// Select rises with the final falling edge, so only rising edges are judged
			if (sck_out === 1'b1 && sel_n_out !== 1'b0) sel_bad = 1'b1;
			toggles++;
			gap = 1;
		end else begin
			gap++;
		end
		last_sck = sck_out;
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			print_verdict();
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Tasks; all but print_verdict are entered just after a falling edge
	task automatic print_verdict();
		if (bad_count == 0 && comparisons > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic wr1(input scf_ctl1_t v);
		ctl1_wr = 1'b1;
		ctl1_wdata = v;
		@(negedge clk);
		ctl1_wr = 1'b0;
	endtask

	task automatic wr2(input scf_ctl2_t v);
		ctl2_wr = 1'b1;
		ctl2_wdata = v;
		@(negedge clk);
		ctl2_wr = 1'b0;
	endtask

	// Hand one byte to the data register and clear the clock watch
	task automatic start_tx(input logic [7:0] b);
		toggles = 0;
		gmin = 9999;
		gmax = 0;
		sel_bad = 1'b0;
		peer_reply = b ^ 8'h5a;
		tx_valid = 1'b1;
		tx_data = b;
		@(negedge clk);
		tx_valid = 1'b0;
	endtask

	// Bounded wait for busy to rise and fall, then for the result to land
	task automatic wait_done();
		int n;
		n = 0;
		while (status.busy !== 1'b1 && n < 64) begin
			@(negedge clk);
			n++;
		end
		n = 0;
		while (status.busy !== 1'b0 && n < 4000) begin
			@(negedge clk);
			n++;
		end
		repeat (4) @(negedge clk);
	endtask

	// Edge count, select framing, half period, byte seen by the peer
	task automatic check_xfer(input int h, input logic [7:0] b, input bit timing);
		chk("toggles", 8'h10, toggles[7:0]);
		chk("select_low", 8'h00, {7'h00, sel_bad});
		if (timing) begin
			chk("half_min", h[7:0], gmin[7:0]);
			chk("half_max", h[7:0], gmax[7:0]);
		end
		if (h >= 4) chk("peer_byte", b, peer_got);
	endtask

	// Take one received word and clear the done flag
	task automatic pop(input logic [7:0] exp, input bit dchk, input bit dexp = 1'b1);
		chk("rx_valid", 8'h01, {7'h00, rx_valid});
		chk("done_flag", {7'h00, dexp}, {7'h00, status.transfer_done_flag});
		if (dchk) chk("rx_data", exp, rx_data);
		rx_ready = 1'b1;
		done_clr = 1'b1;
		@(negedge clk);
		rx_ready = 1'b0;
		done_clr = 1'b0;
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		bad_count = 0;
		comparisons = 0;
		cyc = 0;
		toggles = 0;
		gap = 0;
		last_sck = 1'b0;
		sel_bad = 1'b0;
		rst = 1'b1;
		{ctl1_wr, ctl2_wr, status_rd, done_clr, wait_mode, tx_valid, rx_ready} = 7'h00;
		ctl1_wdata = '0;
		ctl2_wdata = '0;
		baud = '0;
		tx_data = 8'h00;
		ext_sel_n = 1'b1;
		peer_reply = 8'h00;
		repeat (3) @(negedge clk);
		rst = 1'b0;
		repeat (4) @(negedge clk);
		chk("status", 8'h00, {4'h0, status});
		chk("ctl", 8'h00, {1'b0, ctl1, ctl2});
		chk("rx_data", 8'h00, rx_data);
		chk("pins", 8'h82, {tx_ready, rx_valid, sck_oe, mosi_oe, miso_oe, sel_n_oe, sel_n_out, sck_out});
		// Divider table with auto select; halves 1 to 8
		wr1(4'hf);
		for (int i = 0; i < 7; i++) begin
			baud = {pre_t[i][2:0], sel_t[i][2:0]};
			half = (pre_t[i] + 1) * (2 ** (sel_t[i] + 1)) / 2;
			start_tx(8'h3c + 8'(i));
			wait_done();
			check_xfer(half, 8'h3c + 8'(i), 1'b1);
			// Master input passes the pin filter: five cycles late, so data needs half >= 6
			pop((8'h3c + 8'(i)) ^ 8'h5a, half >= 6);
		end
		// Disabled unit keeps the byte; control still writable
		wr1(4'h7);
		chk("ctl1", 8'h07, {4'h0, ctl1});
		start_tx(8'ha5);
		repeat (40) @(negedge clk);
		chk("disabled", 8'h00, {toggles[6:0], status.busy});
		wr1(4'hf);
		wait_done();
		check_xfer(half, 8'ha5, 1'b1);
		pop(8'ha5 ^ 8'h5a, 1'b1);
		// Wait with stop-in-wait freezes the master mid byte
		wr2(3'h1);
		start_tx(8'h96);
		repeat (40) @(negedge clk);
		wait_mode = 1'b1;
		repeat (4) @(negedge clk);
		snap = toggles;
		repeat (30) @(negedge clk);
		chk("frozen", snap[7:0], toggles[7:0]);
		wait_mode = 1'b0;
		wait_done();
		check_xfer(half, 8'h96, 1'b0);
		pop(8'h96 ^ 8'h5a, 1'b1);
		wr2(3'h0);
		// Receiver stall: two words buffered, the third must wait
		for (int i = 0; i < 3; i++) begin
			start_tx(8'h10 + 8'(i));
			wait_done();
		end
		chk("stall", 8'h00, {toggles[6:0], status.busy});
		pop(8'h10 ^ 8'h5a, 1'b1);
		wait_done();
		pop(8'h11 ^ 8'h5a, 1'b1);
		pop(8'h12 ^ 8'h5a, 1'b1, 1'b0);
		chk("drained", 8'h00, {7'h00, rx_valid});
		// Mode fault in single-pin master
		wr2(3'h6);
		wr1(4'hd);
		ext_sel_n = 1'b0;
		repeat (8) @(negedge clk);
		chk("fault", 8'h01, {7'h00, status.fault_flag});
		chk("released", 8'h00, {3'h0, ctl1.master_select, ctl2.single_pin_output_enable, sck_oe, mosi_oe, miso_oe});
		ext_sel_n = 1'b1;
		repeat (8) @(negedge clk);
		wr1(4'hd);
		repeat (2) @(negedge clk);
		chk("no_clear", 8'h01, {7'h00, status.fault_flag});
		status_rd = 1'b1;
		@(negedge clk);
		status_rd = 1'b0;
		wr1(4'hd);
		repeat (2) @(negedge clk);
		chk("cleared", 8'h00, {7'h00, status.fault_flag});
		// Fault detect off: select low is ignored
		wr1(4'hc);
		ext_sel_n = 1'b0;
		repeat (8) @(negedge clk);
		chk("ignored", 8'h01, {6'h00, status.fault_flag, ctl1.master_select});
		ext_sel_n = 1'b1;
		print_verdict();
	end
endmodule
